// [hw/serial_port.sv]
// terminal-side rs232 port: async framer, receiver and modem control lines
// assumes pins arrive asynchronously and a host on the same clock
//
// How it works
// - transmit line rests at mark whenever no character is in flight.
// - request to send raised while the host offers data; in full duplex also while terminal ready is on.
// - terminal ready output follows host; dropping it hangs up the modem.
// - terminal drives its own transmit timing clock at the bit rate.
// - host-controlled local loopback output to the local modem.
// - host-controlled remote loopback output, relayed by the local modem.
// - signal quality off marks the received character as suspect.
// - host drives the data rate select line.
// - secondary request follows the host; secondary clear and carrier lines are reported to it.
// - odd or even parity bit appended and checked; none sends no bit.
// - mark parity sends a one, space parity sends a zero.
// - eight data, one stop, no parity gives ten bit periods.
// - seven data, one stop, no parity gives nine bit periods.
// - eight data, even parity, one stop gives eleven bit periods.
// - in half duplex request to send drops once the data is sent.
// - frame is start, data, optional parity, then one or two stops.
`timescale 1ns/10ps
module serial_port (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [15:0] bit_div,
  input wire logic eight_bits,
  input wire serial_port_pkg::parity_t parity_mode,
  input wire logic two_stops,
  input wire logic half_duplex,
  input wire logic cts_flow,
  input wire logic dtr_en,
  input wire logic local_loop_en,
  input wire logic remote_loop_en,
  input wire logic rate_sel_en,
  input wire logic sec_rts_en,
  input wire logic ring_clear,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic rx_suspect,
  output logic dsr_on,
  output logic dcd_on,
  output logic cts_on,
  output logic test_mode_on,
  output logic sec_cd_on,
  output logic sec_cts_on,
  output logic ring_seen,
  output logic ring_pulse,
  input wire logic rxd_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic dcd_pin,
  input wire logic ri_pin,
  input wire logic sq_pin,
  input wire logic tm_pin,
  input wire logic sec_cd_pin,
  input wire logic sec_cts_pin,
  output logic txd_pin,
  output logic rts_pin,
  output logic dtr_pin,
  output logic local_loop_pin,
  output logic remote_loop_pin,
  output logic rate_sel_pin,
  output logic sec_rts_pin,
  output logic term_tc_pin
);

  typedef struct packed {
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic ri_prev;
    logic ring_seen;
    logic ring_pulse;
    logic rts;
    logic dtr;
    logic lloop;
    logic rloop;
    logic rsel;
    logic sec_rts;
    logic tc;
    logic [15:0] tc_cnt;
    serial_port_pkg::tx_state_t tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_bit;
    logic [15:0] tx_cnt;
    logic tx_par;
    logic txd;
    serial_port_pkg::rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [15:0] rx_cnt;
    logic rx_acc;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
    logic rx_susp;
  } state_t;

  state_t q;
  state_t d;
  logic [8:0] s;
  logic [3:0] nbits;
  logic tx_tick;
  logic rx_tick;
  logic rx_mid;
  logic tx_take;
  logic par_expect;

  assign s = q.sync2;
  assign nbits = eight_bits ? serial_port_pkg::BITS_8 : serial_port_pkg::BITS_7;
  assign tx_tick = (q.tx_cnt == bit_div - 16'h0001);
  assign rx_tick = (q.rx_cnt == bit_div - 16'h0001);
  assign rx_mid = (q.rx_cnt == {1'b0, bit_div[15:1]});
  assign tx_ready = (q.tx_st == serial_port_pkg::TX_IDLE) && (!cts_flow || s[serial_port_pkg::S_CTS]);
  assign tx_take = tx_ready && tx_valid;

  // expected check bit for the received data
  always_comb begin
    par_expect = 1'b0;
    unique case (parity_mode)
      serial_port_pkg::PAR_ODD: par_expect = ~^q.rx_sh;
      serial_port_pkg::PAR_EVEN: par_expect = ^q.rx_sh;
      serial_port_pkg::PAR_MARK: par_expect = 1'b1;
      serial_port_pkg::PAR_SPACE: par_expect = 1'b0;
      serial_port_pkg::PAR_NONE: par_expect = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    d.sync1 = {sec_cts_pin, sec_cd_pin, tm_pin, sq_pin, ri_pin, dcd_pin, dsr_pin, cts_pin, rxd_pin};
    d.sync2 = q.sync1;
    ////////////////////////////////////////////////////////////////////////////////
    // modem control
    d.ri_prev = s[serial_port_pkg::S_RI];
    d.ring_pulse = s[serial_port_pkg::S_RI] && !q.ri_prev;
    d.ring_seen = d.ring_pulse || (q.ring_seen && !ring_clear);
    d.dtr = dtr_en;
    d.lloop = local_loop_en;
    d.rloop = remote_loop_en;
    d.rsel = rate_sel_en;
    d.sec_rts = sec_rts_en;
    if (half_duplex) begin
      d.rts = tx_valid || (q.tx_st != serial_port_pkg::TX_IDLE);
    end else begin
      d.rts = dtr_en || tx_valid;
    end
    // terminal transmit timing clock, one cycle per bit period
    d.tc_cnt = q.tc_cnt + 16'h0001;
    if (q.tc_cnt == bit_div - 16'h0001) begin
      d.tc_cnt = '0;
      d.tc = 1'b1;
    end else if (q.tc_cnt == {1'b0, bit_div[15:1]}) begin
      d.tc = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // transmitter
    d.tx_cnt = tx_tick ? '0 : q.tx_cnt + 16'h0001;
    unique case (q.tx_st)
      serial_port_pkg::TX_IDLE: begin
        d.txd = 1'b1;
        d.tx_cnt = '0;
        if (tx_take) begin
          d.tx_sh = eight_bits ? tx_data : {1'b0, tx_data[6:0]};
          unique case (parity_mode)
            serial_port_pkg::PAR_ODD: d.tx_par = ~^d.tx_sh;
            serial_port_pkg::PAR_EVEN: d.tx_par = ^d.tx_sh;
            serial_port_pkg::PAR_MARK: d.tx_par = 1'b1;
            serial_port_pkg::PAR_SPACE: d.tx_par = 1'b0;
            serial_port_pkg::PAR_NONE: d.tx_par = 1'b1;
          endcase
          d.tx_bit = '0;
          d.txd = 1'b0;
          d.tx_st = serial_port_pkg::TX_START;
        end
      end
      serial_port_pkg::TX_START: begin
        if (tx_tick) begin
          d.txd = q.tx_sh[0];
          d.tx_sh = {1'b0, q.tx_sh[7:1]};
          d.tx_bit = 4'h1;
          d.tx_st = serial_port_pkg::TX_DATA;
        end
      end
      serial_port_pkg::TX_DATA: begin
        if (tx_tick) begin
          if (q.tx_bit == nbits) begin
            d.tx_bit = '0;
            if (parity_mode == serial_port_pkg::PAR_NONE) begin
              d.txd = 1'b1;
              d.tx_st = serial_port_pkg::TX_STOP;
            end else begin
              d.txd = q.tx_par;
              d.tx_st = serial_port_pkg::TX_PAR;
            end
          end else begin
            d.txd = q.tx_sh[0];
            d.tx_sh = {1'b0, q.tx_sh[7:1]};
            d.tx_bit = q.tx_bit + 4'h1;
          end
        end
      end
      serial_port_pkg::TX_PAR: begin
        if (tx_tick) begin
          d.txd = 1'b1;
          d.tx_bit = '0;
          d.tx_st = serial_port_pkg::TX_STOP;
        end
      end
      serial_port_pkg::TX_STOP: begin
        d.txd = 1'b1;
        if (tx_tick) begin
          if (two_stops && q.tx_bit == 4'h0) begin
            d.tx_bit = 4'h1;
          end else begin
            d.tx_st = serial_port_pkg::TX_IDLE;
          end
        end
      end
    endcase
    ////////////////////////////////////////////////////////////////////////////////
    // receiver
    d.rx_valid = 1'b0;
    d.rx_cnt = rx_tick ? '0 : q.rx_cnt + 16'h0001;
    unique case (q.rx_st)
      serial_port_pkg::RX_IDLE: begin
        d.rx_cnt = '0;
        if (!s[serial_port_pkg::S_RXD]) begin
          d.rx_cnt = 16'h0001; // count detect cycle, samples land mid-bit
          d.rx_st = serial_port_pkg::RX_START;
        end
      end
      serial_port_pkg::RX_START: begin
        if (rx_mid) begin
          d.rx_cnt = '0;
          d.rx_bit = '0;
          d.rx_sh = '0;
          d.rx_st = s[serial_port_pkg::S_RXD] ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
        end
      end
      serial_port_pkg::RX_DATA: begin
        if (rx_tick) begin
          d.rx_sh = eight_bits ? {s[serial_port_pkg::S_RXD], q.rx_sh[7:1]}
                               : {1'b0, s[serial_port_pkg::S_RXD], q.rx_sh[6:1]};
          d.rx_bit = q.rx_bit + 4'h1;
          if (d.rx_bit == nbits) begin
            d.rx_st = (parity_mode == serial_port_pkg::PAR_NONE) ? serial_port_pkg::RX_STOP
                                                                  : serial_port_pkg::RX_PAR;
          end
        end
      end
      serial_port_pkg::RX_PAR: begin
        if (rx_tick) begin
          d.rx_acc = (s[serial_port_pkg::S_RXD] != par_expect);
          d.rx_st = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: begin
        if (rx_tick) begin
          d.rx_data = q.rx_sh;
          d.rx_valid = 1'b1;
          d.rx_perr = (parity_mode != serial_port_pkg::PAR_NONE) && q.rx_acc;
          d.rx_ferr = !s[serial_port_pkg::S_RXD];
          d.rx_susp = !s[serial_port_pkg::S_SQ];
          d.rx_acc = 1'b0;
          d.rx_st = serial_port_pkg::RX_IDLE;
        end
      end
    endcase
    if (!reset_n) begin
      d = '0;
      d.txd = 1'b1;
      d.sync1 = serial_port_pkg::SYNC_RESET;
      d.sync2 = serial_port_pkg::SYNC_RESET;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign txd_pin = q.txd;
  assign rts_pin = q.rts;
  assign dtr_pin = q.dtr;
  assign local_loop_pin = q.lloop;
  assign remote_loop_pin = q.rloop;
  assign rate_sel_pin = q.rsel;
  assign sec_rts_pin = q.sec_rts;
  assign term_tc_pin = q.tc;
  assign rx_data = q.rx_data;
  assign rx_valid = q.rx_valid;
  assign rx_parity_err = q.rx_perr;
  assign rx_frame_err = q.rx_ferr;
  assign rx_suspect = q.rx_susp;
  assign dsr_on = s[serial_port_pkg::S_DSR];
  assign dcd_on = s[serial_port_pkg::S_DCD];
  assign cts_on = s[serial_port_pkg::S_CTS];
  assign test_mode_on = s[serial_port_pkg::S_TM];
  assign sec_cd_on = s[serial_port_pkg::S_SEC_CD];
  assign sec_cts_on = s[serial_port_pkg::S_SEC_CTS];
  assign ring_seen = q.ring_seen;
  assign ring_pulse = q.ring_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_idle_mark;
    @(posedge clock) disable iff (!reset_n)
      (q.tx_st == serial_port_pkg::TX_IDLE) |-> txd_pin;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not at mark when idle");

  property p_wait_cts;
    @(posedge clock) disable iff (!reset_n)
      (cts_flow && !cts_on && q.tx_st == serial_port_pkg::TX_IDLE) |=> (q.tx_st == serial_port_pkg::TX_IDLE);
  endproperty
  a_wait_cts: assert property (p_wait_cts) else $error("frame started without cts");

  property p_dtr;
    @(posedge clock) disable iff (!reset_n)
      ##1 (dtr_pin == $past(dtr_en));
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr does not follow host");

  property p_start_space;
    @(posedge clock) disable iff (!reset_n)
      (q.tx_st == serial_port_pkg::TX_START) |-> !txd_pin;
  endproperty
  a_start_space: assert property (p_start_space) else $error("start bit not space");

  property p_stop_mark;
    @(posedge clock) disable iff (!reset_n)
      (q.tx_st == serial_port_pkg::TX_STOP) |-> txd_pin;
  endproperty
  a_stop_mark: assert property (p_stop_mark) else $error("stop bit not mark");

  property p_half_rts;
    @(posedge clock) disable iff (!reset_n)
      (half_duplex && !tx_valid && q.tx_st == serial_port_pkg::TX_IDLE) |=> !rts_pin;
  endproperty
  a_half_rts: assert property (p_half_rts) else $error("rts held after data sent");

  property p_ring;
    @(posedge clock) disable iff (!reset_n)
      (s[serial_port_pkg::S_RI] && !q.ri_prev) |=> (ring_seen && ring_pulse);
  endproperty
  a_ring: assert property (p_ring) else $error("ring not flagged");

  property p_par_fixed;
    @(posedge clock) disable iff (!reset_n)
      (q.tx_st == serial_port_pkg::TX_PAR && parity_mode == serial_port_pkg::PAR_MARK) |-> txd_pin;
  endproperty
  a_par_fixed: assert property (p_par_fixed) else $error("mark parity not sent as one");

  property p_no_par;
    @(posedge clock) disable iff (!reset_n)
      (parity_mode == serial_port_pkg::PAR_NONE) |-> (q.tx_st != serial_port_pkg::TX_PAR);
  endproperty
  a_no_par: assert property (p_no_par) else $error("parity bit sent with none");

  property p_suspect;
    @(posedge clock) disable iff (!reset_n)
      (q.rx_st == serial_port_pkg::RX_STOP && rx_tick && !s[serial_port_pkg::S_SQ]) |=> rx_suspect;
  endproperty
  a_suspect: assert property (p_suspect) else $error("poor quality not flagged");

  c_send: cover property (@(posedge clock) disable iff (!reset_n) tx_take);
  c_recv: cover property (@(posedge clock) disable iff (!reset_n) rx_valid);
  c_perr: cover property (@(posedge clock) disable iff (!reset_n) rx_valid && rx_parity_err);
  c_ring: cover property (@(posedge clock) disable iff (!reset_n) ring_pulse);

endmodule : serial_port

// [hw/serial_port_pkg.sv]
// serial port package: sync bit positions, parity modes, engine states
// assumes one 40 MHz clock and a host that programs the bit divisor
package serial_port_pkg;

  // positions in the pin synchroniser vector
  localparam int SYNC_W = 9;
  localparam int S_RXD = 0;
  localparam int S_CTS = 1;
  localparam int S_DSR = 2;
  localparam int S_DCD = 3;
  localparam int S_RI = 4;
  localparam int S_SQ = 5;
  localparam int S_TM = 6;
  localparam int S_SEC_CD = 7;
  localparam int S_SEC_CTS = 8;
  // synchroniser reset value: receive line at mark, all indications off
  localparam logic [8:0] SYNC_RESET = 9'h001;

  // frame shape
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_7 = 4'h7;

  typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE} parity_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage : serial_port_pkg

// [testbench/dce_model.sv]
// dce model: receive data frames and modem indications toward the port
// assumes the bench calls set_lines and send just after a rising edge
`timescale 1ns/10ps
module dce_model #(
  parameter int DIV = 4
) (
  input wire logic clock,
  output logic rxd_pin,
  output logic cts_pin,
  output logic dsr_pin,
  output logic dcd_pin,
  output logic ri_pin,
  output logic sq_pin,
  output logic tm_pin,
  output logic sec_cd_pin,
  output logic sec_cts_pin,
  output logic rc_pin
);
  logic [8:0] lines_q = 9'h000;
  logic line_q = 1'b1;
  logic rc_q = 1'b0;
  assign rc_pin = rc_q;
  assign rxd_pin = lines_q[serial_port_pkg::S_DCD] ? line_q : 1'b1;
  assign cts_pin = lines_q[serial_port_pkg::S_CTS];
  assign dsr_pin = lines_q[serial_port_pkg::S_DSR];
  assign dcd_pin = lines_q[serial_port_pkg::S_DCD];
  assign ri_pin = lines_q[serial_port_pkg::S_RI];
  assign sq_pin = lines_q[serial_port_pkg::S_SQ];
  assign tm_pin = lines_q[serial_port_pkg::S_TM];
  assign sec_cd_pin = lines_q[serial_port_pkg::S_SEC_CD];
  assign sec_cts_pin = lines_q[serial_port_pkg::S_SEC_CTS];
  task set_lines(input logic [8:0] v);
    lines_q = v;
  endtask : set_lines
  // bits lsb first, one bit period each, mark afterwards
  task send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_q = f[i];
      rc_q = 1'b0;
      repeat (DIV / 2) @(posedge clock);
      #2;
      rc_q = 1'b1; // receive timing rises mid-bit
      repeat (DIV - DIV / 2) @(posedge clock);
      #2;
    end
    line_q = 1'b1;
  endtask : send
endmodule : dce_model

// [testbench/testbench.sv]
// bench: random and corner frames both ways, modem line mirroring
// assumes serial_port and dce_model compiled before it
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam int DIV = 4;
  logic clock = 1'b0;
  logic [15:0] bit_div;
  logic [7:0] tx_data, rx_data;
  serial_port_pkg::parity_t parity_mode;
  logic reset_n, eight_bits, two_stops, half_duplex, cts_flow, dtr_en, local_loop_en;
  logic remote_loop_en, rate_sel_en, sec_rts_en, ring_clear, tx_valid, tx_ready, rx_valid;
  logic rx_parity_err, rx_frame_err, rx_suspect, dsr_on, dcd_on, cts_on, test_mode_on;
  logic sec_cd_on, sec_cts_on, ring_seen, ring_pulse, rxd_pin, cts_pin, dsr_pin, dcd_pin;
  logic ri_pin, sq_pin, tm_pin, sec_cd_pin, sec_cts_pin, txd_pin, rts_pin, dtr_pin;
  logic local_loop_pin, remote_loop_pin, rate_sel_pin, sec_rts_pin, term_tc_pin;
  logic tc_prev;
  logic [31:0] rng_q = 32'h00006c4b;
  logic [31:0] v;
  int fail_count = 0;
  int n_compared = 0;
  int c;
  always #12.5 clock = ~clock;
  serial_port dut (.clock, .reset_n, .bit_div, .eight_bits, .parity_mode, .two_stops,
    .half_duplex, .cts_flow, .dtr_en, .local_loop_en, .remote_loop_en, .rate_sel_en,
    .sec_rts_en, .ring_clear, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_parity_err, .rx_frame_err, .rx_suspect, .dsr_on, .dcd_on, .cts_on, .test_mode_on,
    .sec_cd_on, .sec_cts_on, .ring_seen, .ring_pulse, .rxd_pin, .cts_pin, .dsr_pin,
    .dcd_pin, .ri_pin, .sq_pin, .tm_pin, .sec_cd_pin, .sec_cts_pin, .txd_pin, .rts_pin,
    .dtr_pin, .local_loop_pin, .remote_loop_pin, .rate_sel_pin, .sec_rts_pin, .term_tc_pin);
  dce_model #(.DIV(DIV)) dce (.clock, .rxd_pin, .cts_pin, .dsr_pin, .dcd_pin, .ri_pin,
    .sq_pin, .tm_pin, .sec_cd_pin, .sec_cts_pin, .rc_pin());
  ////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction : rnd
  function automatic logic par(input logic [7:0] d, input serial_port_pkg::parity_t m);
    if (m == serial_port_pkg::PAR_ODD) return ~^d;
    if (m == serial_port_pkg::PAR_EVEN) return ^d;
    return m == serial_port_pkg::PAR_MARK;
  endfunction : par
  function automatic int flen(input logic eb, input serial_port_pkg::parity_t m);
    return (eb ? 10 : 9) + ((m != serial_port_pkg::PAR_NONE) ? 1 : 0);
  endfunction : flen
  function automatic logic [11:0] frame(input logic [7:0] d, input logic eb,
      input serial_port_pkg::parity_t m, input logic bad);
    logic [11:0] f;
    f = 12'hffe;
    for (int i = 0; i < (eb ? 8 : 7); i++) f[i + 1] = d[i];
    if (m != serial_port_pkg::PAR_NONE) f[eb ? 9 : 8] = par(d & (eb ? 8'hff : 8'h7f), m) ^ bad;
    return f;
  endfunction : frame
  task step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  ////////////////////////////////////////////////////////////////
  task tx_chk(input logic [7:0] d, input serial_port_pkg::parity_t m, input logic eb,
      input logic ts);
    logic [11:0] f;
    int n;
    f = frame(d, eb, m, 1'b0);
    n = flen(eb, m) + ts;
    eight_bits = eb; parity_mode = m; two_stops = ts; tx_data = d; tx_valid = 1'b1;
    c = 0;
    while (tx_ready !== 1'b1 && c < 200) begin step(1); c++; end
    step(1);
    tx_valid = 1'b0;
    step(DIV / 2);
    for (int i = 0; i < n; i++) begin
      `CHK("txd bit", f[i], txd_pin)
      if (i == n - 1) `CHK("tx busy", 1'b0, tx_ready)
      step(DIV);
    end
    `CHK("tx idle", 1'b1, tx_ready)
    `CHK("txd mark", 1'b1, txd_pin)
  endtask : tx_chk
  task rx_chk(input logic [7:0] d, input serial_port_pkg::parity_t m, input logic eb,
      input logic bad, input logic sq, input logic fe);
    eight_bits = eb; parity_mode = m;
    // cts, dsr and dcd on, quality as asked
    dce.set_lines({3'h0, sq, 1'b0, 3'h7, 1'b0});
    step(3);
    fork
      dce.send(frame(d, eb, m, bad) & ~({11'h000, fe} << (flen(eb, m) - 1)), flen(eb, m));
      begin
        c = 0;
        while (rx_valid !== 1'b1 && c < 200) begin step(1); c++; end
        `CHK("rx valid", 1'b1, rx_valid)
        `CHK("rx data", eb ? d : {1'b0, d[6:0]}, rx_data)
        `CHK("rx parity", bad, rx_parity_err)
        `CHK("rx frame", fe, rx_frame_err)
        `CHK("rx suspect", ~sq, rx_suspect)
      end
    join
  endtask : rx_chk
  ////////////////////////////////////////////////////////////////
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    #(25 * 40000);
    fail_count++;
    end_of_test();
  end
  initial begin
    {reset_n, eight_bits, two_stops, half_duplex, cts_flow, dtr_en, local_loop_en} = '0;
    {remote_loop_en, rate_sel_en, sec_rts_en, ring_clear, tx_valid} = '0;
    bit_div = 16'h0004; tx_data = 8'h00; parity_mode = serial_port_pkg::PAR_NONE;
    step(5);
    reset_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      {dtr_en, local_loop_en, remote_loop_en, rate_sel_en, sec_rts_en} = v[4:0];
      dce.set_lines(v[17:9] & 9'h1ee);
      step(4);
      `CHK("dtr pin", v[4], dtr_pin)
      `CHK("loop pins", v[3:2], {local_loop_pin, remote_loop_pin})
      `CHK("rate sel pin", v[1], rate_sel_pin)
      `CHK("sec rts pin", v[0], sec_rts_pin)
      `CHK("status a", {v[10], v[11], v[12]}, {cts_on, dsr_on, dcd_on})
      `CHK("status b", {v[15], v[16], v[17]}, {test_mode_on, sec_cd_on, sec_cts_on})
    end
    // terminal timing clock: one rise per bit period
    tc_prev = term_tc_pin;
    c = 0;
    repeat (4 * DIV) begin step(1); c += term_tc_pin & ~tc_prev; tc_prev = term_tc_pin; end
    `CHK("tc rises", 4, c)
    dtr_en = 1'b0; ring_clear = 1'b1;
    dce.set_lines(9'h010);
    step(1);
    ring_clear = 1'b0;
    c = 0;
    repeat (6) begin step(1); c += ring_pulse; end
    `CHK("ring pulses", 1, c)
    `CHK("ring seen", 1'b1, ring_seen)
    dce.set_lines(9'h000); ring_clear = 1'b1;
    step(4);
    ring_clear = 1'b0;
    `CHK("ring cleared", 1'b0, ring_seen)
    cts_flow = 1'b1; tx_valid = 1'b1;
    step(5);
    `CHK("held by cts", 2'h1, {tx_ready, txd_pin})
    `CHK("rts asked", 1'b1, rts_pin)
    dce.set_lines(9'h02a);
    for (int k = 0; k < 10; k++) begin
      v = rnd();
      tx_chk(k == 0 ? 8'hff : v[7:0], serial_port_pkg::parity_t'(k % 5), k[0] ^ v[8], v[9]);
      rx_chk(v[23:16], serial_port_pkg::parity_t'(k % 5), k[1] ^ v[24],
        (k % 5 != 0) & v[25], v[26] | k[0], k == 9);
    end
    half_duplex = 1'b1; dtr_en = 1'b1;
    dce.set_lines(9'h02a);
    step(3);
    tx_chk(8'h00, serial_port_pkg::PAR_EVEN, 1'b1, 1'b0);
    step(2);
    `CHK("rts turnaround", 1'b0, rts_pin)
    end_of_test();
  end
endmodule : testbench
